/* File: src/nvm_org_regs.vh */
// Constants for the nonvolatile memory organisation block
`ifndef NVM_ORG_REGS_VH
`define NVM_ORG_REGS_VH
// Program array boundaries, byte addresses
`define PGM_ARRAY_TOP 16'hffff
`define PGM_USER_TOP 16'hf7ff
`define PGM_HIDDEN_BASE 16'hf800
`define PGM_KERNEL_BASE 16'hf000
`define PGM_USER_DOWNLOAD_MODE_TOP_62K 16'hdfff
// Per memory model user top and download base
`define MODEL_62K 2'h0
`define MODEL_32K 2'h1
`define MODEL_8K 2'h2
`define TOP_32K 16'h7fff
`define TOP_8K 16'h1fff
`define DL_BASE_62K 16'he000
`define DL_BASE_32K 16'h6800
`define DL_BASE_8K 16'h0800
// Data memory: 4 kbytes, 4-byte pages
`define DATA_AW 12
`define DATA_PAGE_BYTES 4
`define ERASED_BYTE 8'hff
// Data memory commands
`define CMD_READ 3'h1
`define CMD_PROG 3'h2
`define CMD_ERASE 3'h3
// Boot modes
`define BOOT_NORMAL 1'b0
`define BOOT_SERIAL 1'b1
// Calibration load length in words
`define CAL_WORDS 8'h08
`endif

/* File: src/page_array.v */
// Byte array with page erase and program-only-after-erase guard
`timescale 1ns/1ps
`default_nettype none
`include "nvm_org_regs.vh"
module page_array #(
  parameter AW = 12,
  parameter PAGE_LOG2 = 2
) (
  // Clock
  input wire mclk,
  // Access
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  input wire rd,
  input wire prog,
  input wire erase,
  // Results
  output reg [7:0] rdata,
  output reg prog_fail
);
  reg [7:0] mem [0:(1<<AW)-1];
  reg blank [0:(1<<AW)-1];
  integer i;
  // Cells with blank set can accept one program
  // Page erase, blank-only program
  always @(posedge mclk) begin
    prog_fail <= 1'b0;
    if (rd) begin
      rdata <= mem[addr];
    end
    if (erase) begin
      for (i = 0; i < (1<<PAGE_LOG2); i = i + 1) begin
        mem[{addr[AW-1:PAGE_LOG2], i[PAGE_LOG2-1:0]}] <= `ERASED_BYTE;
        blank[{addr[AW-1:PAGE_LOG2], i[PAGE_LOG2-1:0]}] <= 1'b1;
      end
    end else if (prog) begin
      if (blank[addr] === 1'b1) begin
        mem[addr] <= wdata;
        blank[addr] <= 1'b0;
      end else begin
        prog_fail <= 1'b1;
      end
    end
  end
endmodule // page_array
`default_nettype wire

/* File: src/nvm_org.v */
// Nonvolatile memory organisation: program map, data memory, boot mode
// Summary of operation
// - Bytes program in-system only after their page is erased.
// - 4-kbyte data memory reached only through the command port.
// - Data memory programs bytes, erases 4-byte pages.
// - 64-kbyte program array, lower 62 kbytes for user.
// - Top 2 kbytes hidden firmware; user reads return zero.
// - Power-on runs calibration load before user code starts.
// - Normal mode presents 62 kbytes as one block.
// - Normal mode programs code only via serial or parallel path.
// - Strobe pin low at reset enters serial download kernel.
// - Smaller models: download region is top 6 kbytes.
// - Kernel stays between 60 and 62 kbytes on every model.
// - 8-kbyte model: download region from 2 to 8 kbytes.
// - User download mode lets user code rewrite lower region only; nothing on the 8-kbyte model.
// - Serial-safe protection turns download reset into normal reset.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_org_regs.vh"
module nvm_org #(
  parameter DATA_AW = `DATA_AW
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Pins and configuration
  input wire program_fetch_strobe_pin_n,
  input wire serial_safe,
  input wire [1:0] mem_model,
  input wire user_download_mode,
  // Privileged programming path (serial kernel or parallel)
  input wire priv_prog_req,
  // User code program fetch / write
  input wire [15:0] code_addr,
  input wire code_rd,
  input wire code_wr,
  input wire code_erase,
  output reg [7:0] code_rdata,
  output wire code_write_ok,
  // Data memory command port
  input wire [2:0] dm_cmd,
  input wire dm_go,
  input wire [DATA_AW-1:0] dm_addr,
  input wire [7:0] dm_wdata,
  output wire [7:0] dm_rdata,
  output wire dm_prog_fail,
  output reg dm_busy,
  // Boot status
  output reg boot_mode,
  output reg cal_busy,
  output reg user_run,
  output reg [7:0] cal_index
);
  // ****************************************
  // Pin synchroniser
  // ****************************************
  reg s1_q, s2_q, s3_q, strobe_low_q;
  // Three stages; level counts once stages two and three agree
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      strobe_low_q <= 1'b0;
    end else begin
      s1_q <= program_fetch_strobe_pin_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        strobe_low_q <= ~s3_q;
      end
    end
  end

  // ****************************************
  // Boot sequencer
  // ****************************************
  localparam ST_SYNC = 2'h0;
  localparam ST_CAL = 2'h1;
  localparam ST_RUN = 2'h2;
  reg [1:0] st_q;
  reg [1:0] wait_q;
  // Wait for synchroniser to settle, then calibrate, then choose mode
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_SYNC;
      wait_q <= 2'h0;
      cal_busy <= 1'b0;
      user_run <= 1'b0;
      boot_mode <= `BOOT_NORMAL;
      cal_index <= 8'h00;
    end else begin
      case (st_q)
        ST_SYNC: begin
          wait_q <= wait_q + 2'h1;
          if (wait_q == 2'h3) begin
            st_q <= ST_CAL;
            cal_busy <= 1'b1;
          end
        end
        ST_CAL: begin
          cal_index <= cal_index + 8'h01;
          if (cal_index == `CAL_WORDS - 8'h01) begin
            cal_busy <= 1'b0;
            st_q <= ST_RUN;
            // Strobe low requests kernel unless serial-safe
            if (strobe_low_q && !serial_safe) begin
              boot_mode <= `BOOT_SERIAL;
            end else begin
              boot_mode <= `BOOT_NORMAL;
              user_run <= 1'b1;
            end
          end
        end
        ST_RUN: begin
          st_q <= ST_RUN;
        end
        default: begin
          st_q <= ST_SYNC;
        end
      endcase
    end
  end

  // ****************************************
  // Program memory map
  // ****************************************
  reg [15:0] user_top;
  reg [15:0] dl_base;
  always @* begin
    case (mem_model)
      `MODEL_32K: begin
        user_top = `TOP_32K;
        dl_base = `DL_BASE_32K;
      end
      `MODEL_8K: begin
        user_top = `TOP_8K;
        dl_base = `DL_BASE_8K;
      end
      default: begin
        user_top = `PGM_USER_TOP;
        dl_base = `DL_BASE_62K;
      end
    endcase
  end

  wire in_hidden = code_addr >= `PGM_HIDDEN_BASE;
  wire in_kernel = (code_addr >= `PGM_KERNEL_BASE) && !in_hidden;
  // Writable area in user download mode: below download region, none on the 8-kbyte model
  wire below_dl = (mem_model == `MODEL_8K) ? 1'b0 : (code_addr < dl_base);
  // User download mode or privileged request opens writes; hidden space always refused
  assign code_write_ok = (user_download_mode && below_dl && !in_kernel && !in_hidden &&
                          code_addr <= user_top) || (priv_prog_req && !in_hidden);

  reg [7:0] code_mem [0:16'hf7ff];
  reg [7:0] code_blank [0:16'hf7ff];
  integer k;
  // Single user block; program needs erased page
  always @(posedge mclk) begin
    if (code_rd) begin
      if (in_hidden || code_addr > user_top) begin
        code_rdata <= 8'h00;
      end else begin
        code_rdata <= code_mem[code_addr];
      end
    end
    if (code_erase && code_write_ok) begin
      for (k = 0; k < `DATA_PAGE_BYTES; k = k + 1) begin
        code_mem[{code_addr[15:2], k[1:0]}] <= `ERASED_BYTE;
        code_blank[{code_addr[15:2], k[1:0]}] <= 8'h01;
      end
    end else if (code_wr && code_write_ok && code_blank[code_addr] == 8'h01) begin
      code_mem[code_addr] <= dm_wdata;
      code_blank[code_addr] <= 8'h00;
    end
  end

  // ****************************************
  // Data memory
  // ****************************************
  // Command port; byte program, page erase
  wire dm_rd = dm_go && (dm_cmd == `CMD_READ);
  wire dm_pg = dm_go && (dm_cmd == `CMD_PROG);
  wire dm_er = dm_go && (dm_cmd == `CMD_ERASE);
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dm_busy <= 1'b0;
    end else begin
      dm_busy <= dm_go;
    end
  end
  page_array #(.AW(DATA_AW), .PAGE_LOG2(2)) u_data (
    .mclk(mclk),
    .addr(dm_addr),
    .wdata(dm_wdata),
    .rd(dm_rd),
    .prog(dm_pg),
    .erase(dm_er),
    .rdata(dm_rdata),
    .prog_fail(dm_prog_fail)
  );
endmodule // nvm_org
`default_nettype wire

/* File: tb/dl_host.sv */
// Host model that requests serial download through the fetch strobe pin
`timescale 1ns/1ps
`default_nettype none
module dl_host (
  // Request from the bench
  input wire logic want_dl,
  // Pin toward the device, pulled up when released
  output logic program_fetch_strobe_pin_n
);
  // hold pin low
  // Released pin rests at its pull-up level
  assign program_fetch_strobe_pin_n = want_dl ? 1'b0 : 1'b1;
endmodule // dl_host
`default_nettype wire

/* File: tb/nvm_org_checker.sv */
// Port checker for the memory organisation block
`timescale 1ns/1ps
`default_nettype none
module nvm_org_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Configuration and accesses
  input wire logic serial_safe,
  input wire logic [1:0] mem_model,
  input wire logic user_download_mode,
  input wire logic priv_prog_req,
  input wire logic [15:0] code_addr,
  input wire logic code_rd,
  input wire logic dm_go,
  // Results and status
  input wire logic [7:0] code_rdata,
  input wire logic code_write_ok,
  input wire logic dm_busy,
  input wire logic boot_mode,
  input wire logic cal_busy,
  input wire logic user_run
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_hidden_read_zero: assert property (code_rd && code_addr >= 16'hf800 |=> code_rdata == 8'h00)
    else $error("hidden region read not zero");
  a_model_top_zero: assert property (code_rd && mem_model == 2'h1 && code_addr > 16'h7fff |=> code_rdata == 8'h00)
    else $error("read above model top not zero");
  a_hidden_write_refused: assert property (code_addr >= 16'hf800 |-> !code_write_ok)
    else $error("hidden region writable");
  a_normal_read_only: assert property (!user_download_mode && !priv_prog_req |-> !code_write_ok)
    else $error("user write allowed in normal mode");
  a_upper_kept: assert property (!priv_prog_req && mem_model == 2'h0 && code_addr > 16'hdfff |-> !code_write_ok)
    else $error("protected upper space writable");
  a_cal_first: assert property (cal_busy |-> !user_run)
    else $error("user code runs during calibration");
  a_cal_length: assert property ($rose(cal_busy) |-> cal_busy [*8] ##1 !cal_busy)
    else $error("calibration length wrong");
  a_safe_normal: assert property ($rose(user_run) && serial_safe |-> !boot_mode)
    else $error("download entered under protection");
  a_busy_follow: assert property (dm_go |=> dm_busy)
    else $error("busy did not follow go");
  a_small_locked: assert property (!priv_prog_req && mem_model == 2'h2 |-> !code_write_ok)
    else $error("user write allowed on smallest model");
  c_protected_boot: cover property ($rose(user_run) && serial_safe);
  c_kernel: cover property ($rose(boot_mode));
  c_user_write: cover property (code_write_ok && user_download_mode);
  c_cal_done: cover property ($fell(cal_busy));
endmodule // nvm_org_checker
bind nvm_org nvm_org_checker chk_u (.mclk, .nrst, .serial_safe, .mem_model, .user_download_mode, .priv_prog_req,
  .code_addr, .code_rd, .dm_go, .code_rdata, .code_write_ok, .dm_busy, .boot_mode, .cal_busy, .user_run);
`default_nettype wire

/* File: tb/nvm_org_tb_top.sv */
// Self-checking bench for the memory organisation block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module nvm_org_tb_top;
  logic mclk = 0, nrst = 0, want_dl = 0, serial_safe = 0, user_download_mode = 0, priv_prog_req = 0;
  logic code_rd = 0, code_wr = 0, code_erase = 0, dm_go = 0, code_write_ok, dm_prog_fail, dm_busy;
  logic boot_mode, cal_busy, user_run, pin_n, fail;
  logic [1:0] mem_model = 2'h0;
  logic [2:0] dm_cmd = 3'h0;
  logic [15:0] code_addr = 16'h0000;
  logic [11:0] dm_addr = 12'h000;
  logic [7:0] dm_wdata = 8'h00, code_rdata, dm_rdata, cal_index;
  int mismatches = 0, n_compared = 0;
  // 50 ns core clock
  always #25 mclk = ~mclk;
  dl_host host_u (.want_dl(want_dl), .program_fetch_strobe_pin_n(pin_n));
  nvm_org dut_u (.mclk(mclk), .nrst(nrst), .program_fetch_strobe_pin_n(pin_n), .serial_safe(serial_safe),
    .mem_model(mem_model), .user_download_mode(user_download_mode), .priv_prog_req(priv_prog_req),
    .code_addr(code_addr), .code_rd(code_rd), .code_wr(code_wr), .code_erase(code_erase), .code_rdata(code_rdata),
    .code_write_ok(code_write_ok), .dm_cmd(dm_cmd), .dm_go(dm_go), .dm_addr(dm_addr), .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata), .dm_prog_fail(dm_prog_fail), .dm_busy(dm_busy), .boot_mode(boot_mode),
    .cal_busy(cal_busy), .user_run(user_run), .cal_index(cal_index));
  // Reset for 3 cycles, then allow sync plus calibration to finish
  task rst(input logic dl, input logic s);
    nrst = 0; want_dl = dl; serial_safe = s;
    repeat (3) @(negedge mclk);
    nrst = 1;
    repeat (16) @(negedge mclk);
  endtask
  // One data command; the fail pulse is caught while it stands
  task dm(input logic [2:0] c, input logic [11:0] a, input logic [7:0] d);
    dm_cmd = c; dm_addr = a; dm_wdata = d; dm_go = 1;
    @(negedge mclk);
    dm_go = 0; fail = dm_prog_fail;
    @(negedge mclk);
  endtask
  // One code access pulse
  task cd(input logic r, input logic w, input logic e, input logic [15:0] a, input logic [7:0] d);
    code_rd = r; code_wr = w; code_erase = e; code_addr = a; dm_wdata = d;
    @(negedge mclk);
    {code_rd, code_wr, code_erase} = 3'h0;
    @(negedge mclk);
  endtask
  task t_boot;
    rst(1, 0); `CHK("boot_mode", 1'b1, boot_mode)
    `CHK("user_run", 1'b0, user_run)
    rst(1, 1); `CHK("boot_mode", 1'b0, boot_mode)
    `CHK("user_run", 1'b1, user_run)
    rst(0, 0); `CHK("boot_mode", 1'b0, boot_mode)
    `CHK("user_run", 1'b1, user_run)
  endtask
  task t_dm;
    dm(3'h3, 12'h005, 8'h00); dm(3'h2, 12'h006, 8'h5a); `CHK("prog_fail", 1'b0, fail)
    dm(3'h1, 12'h006, 8'h00); `CHK("dm_rdata", 8'h5a, dm_rdata)
    dm(3'h1, 12'h004, 8'h00); `CHK("dm_rdata", 8'hff, dm_rdata)
    dm(3'h2, 12'h006, 8'h11); `CHK("prog_fail", 1'b1, fail)
    dm(3'h2, 12'h008, 8'h11); `CHK("prog_fail", 1'b1, fail)
    dm(3'h3, 12'hfff, 8'h00); dm(3'h2, 12'hfff, 8'ha5); dm(3'h1, 12'hfff, 8'h00);
    `CHK("dm_rdata", 8'ha5, dm_rdata)
  endtask
  task t_code;
    user_download_mode = 1;
    cd(0, 0, 1, 16'h0100, 8'h00); cd(0, 1, 0, 16'h0100, 8'hc3); cd(1, 0, 0, 16'h0100, 8'h00);
    `CHK("code_rdata", 8'hc3, code_rdata)
    cd(1, 0, 0, 16'hf900, 8'h00); `CHK("code_rdata", 8'h00, code_rdata)
    code_addr = 16'hd000; #1 `CHK("write_ok", 1'b1, code_write_ok)
    code_addr = 16'he000; #1 `CHK("write_ok", 1'b0, code_write_ok)
    user_download_mode = 0; code_addr = 16'h0100; #1 `CHK("write_ok", 1'b0, code_write_ok)
    priv_prog_req = 1; #1 `CHK("write_ok", 1'b1, code_write_ok)
    priv_prog_req = 0; mem_model = 2'h1; cd(1, 0, 0, 16'h9000, 8'h00);
    `CHK("code_rdata", 8'h00, code_rdata)
    user_download_mode = 1; code_addr = 16'h67fc; #1 `CHK("write_ok", 1'b1, code_write_ok)
    code_addr = 16'h6800; #1 `CHK("write_ok", 1'b0, code_write_ok)
    mem_model = 2'h2; code_addr = 16'h0800; #1 `CHK("write_ok", 1'b0, code_write_ok)
    user_download_mode = 0; cd(1, 0, 0, 16'h2000, 8'h00);
    `CHK("code_rdata", 8'h00, code_rdata)
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run needs about 90 cycles; the limit leaves wide margin
  initial begin
    #100000; mismatches++; conclude;
  end
  initial begin
    @(negedge mclk); t_boot; t_dm; t_code; conclude;
  end
endmodule // nvm_org_tb_top
`default_nettype wire
